// *** core/srfb_consts.svh ***
`ifndef SRFB_CONSTS_SVH
`define SRFB_CONSTS_SVH

// Register word indexes, byte address is index times four
`define SRFB_R_TYPE  0
`define SRFB_R_LPTC  1
`define SRFB_R_N1F   2
`define SRFB_R_N1D   3
`define SRFB_R_N1W   4
`define SRFB_R_N2F   5
`define SRFB_R_N2D   6
`define SRFB_R_N2W   7
`define SRFB_R_N3F   8
`define SRFB_R_N3D   9
`define SRFB_R_N3W   10
`define SRFB_R_N4F   11
`define SRFB_R_N4D   12
`define SRFB_R_N4W   13
`define SRFB_R_LFF   14
`define SRFB_R_LFW   15
`define SRFB_R_LFD   16
`define SRFB_R_PCF   17
`define SRFB_R_PCW   18
`define SRFB_R_PCD   19
`define SRFB_R_PCTC  20
`define SRFB_R_VTHR  21
`define SRFB_R_LIM   22
`define SRFB_R_STAT  23
`define SRFB_R_MASK  24
`define SRFB_R_AUTO  25
`define SRFB_NCFG    22

// Reset values
`define SRFB_RST_ZERO  16'h0000
`define SRFB_RST_LPTC  16'h0050
`define SRFB_RST_DEPTH 16'h0064
`define SRFB_RST_WIDTH 16'h01f4
`define SRFB_RST_PCTC  16'h000a
`define SRFB_RST_VTHR  16'h0064
`define SRFB_RST_LIM   32'h0000000a

// Status bits
`define SRFB_ST_FAULT 0
`define SRFB_ST_VIB   1
`define SRFB_ST_W     2

// Scaling and timing
`define SRFB_TS_SCALE    100000
`define SRFB_PC_TC_MUL   10
`define SRFB_TENTH       10
`define SRFB_TWO_PI_Q15  205887
`define SRFB_F_MAX       16384
`define SRFB_Q_PER_TENTH 65
`define SRFB_DEPTH_FULL  1000
`define SRFB_FRAC        15
`define SRFB_VIB_HZ      200
`define SRFB_STG_N1      1
`define SRFB_STG_SPD     5
`define SRFB_STG_PC      6
`define SRFB_STG_LAST    7
`define SRFB_N_SPD       4
`define SRFB_N_PC        5
`define SRFB_AUTO_BIT    16

`endif

// *** core/srfb_pkg.sv ***
package srfb_pkg;
`include "srfb_consts.svh"

   typedef enum logic [1:0] {SRFB_IDLE = 2'b00, SRFB_RUN = 2'b01} srfb_fsm_t;

   typedef enum logic [15:0] {
      SRFB_FT_LP      = 16'h0000,
      SRFB_FT_NOTCH   = 16'h0001,
      SRFB_FT_NONE    = 16'h0002,
      SRFB_FT_CASCADE = 16'h0003,
      SRFB_FT_AUTO    = 16'h0004
   } srfb_ftype_t;

   typedef struct packed {
      logic [`SRFB_NCFG-1:0][15:0] cfg;
      logic [31:0]                 lim;
      logic [`SRFB_ST_W-1:0]       st;
      logic [`SRFB_ST_W-1:0]       mask;
      logic                        ack;
      logic [31:0]                 rdata;
      srfb_fsm_t                   fsm;
      logic [2:0]                  stg;
      logic signed [23:0]          tq;
      logic signed [23:0]          sp;
      logic signed [23:0]          pc;
      logic [15:0]                 tin;
      logic [15:0]                 sin;
      logic [15:0]                 pin;
      logic [31:0]                 perr;
      logic [5:0][23:0]            nlp;
      logic [5:0][23:0]            nbp;
      logic signed [23:0]          tlp;
      logic signed [23:0]          plp;
      logic                        auto_on;
      logic [15:0]                 est;
      logic [15:0]                 vwin;
      logic [15:0]                 vcnt;
      logic                        vsgn;
      logic [15:0]                 tout;
      logic [15:0]                 sout;
      logic [15:0]                 pout;
      logic                        ovld;
   } srfb_regs_t;
endpackage

// *** core/srfb_top.sv ***
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "srfb_consts.svh"

module srfb_top import srfb_pkg::*; #(
   parameter int SAMPLE_HZ = 10000,
   parameter int VIB_WIN   = 100
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Control samples in
   input  wire logic        sample_valid,
   input  wire logic [15:0] torque_cmd_in,
   input  wire logic [15:0] speed_cmd_in,
   input  wire logic [15:0] pos_cmd_in,
   input  wire logic [31:0] pos_error_in,
   // Filtered samples out
   output logic             out_valid,
   output logic [15:0]      torque_cmd_out,
   output logic [15:0]      speed_cmd_out,
   output logic [15:0]      pos_cmd_out,
   // Events
   output logic             position_error_too_large_fault,
   output logic             irq
);

   localparam longint TS = `SRFB_TS_SCALE / SAMPLE_HZ;

   function automatic srfb_regs_t rst_val();
      srfb_regs_t r;
      r = '0;
      r.cfg[`SRFB_R_LPTC] = `SRFB_RST_LPTC;
      r.cfg[`SRFB_R_N1D] = `SRFB_RST_DEPTH;
      r.cfg[`SRFB_R_N2D] = `SRFB_RST_DEPTH;
      r.cfg[`SRFB_R_N3D] = `SRFB_RST_DEPTH;
      r.cfg[`SRFB_R_N4D] = `SRFB_RST_DEPTH;
      r.cfg[`SRFB_R_LFD] = `SRFB_RST_DEPTH;
      r.cfg[`SRFB_R_N1W] = `SRFB_RST_WIDTH;
      r.cfg[`SRFB_R_N2W] = `SRFB_RST_WIDTH;
      r.cfg[`SRFB_R_N3W] = `SRFB_RST_WIDTH;
      r.cfg[`SRFB_R_N4W] = `SRFB_RST_WIDTH;
      r.cfg[`SRFB_R_LFW] = `SRFB_RST_WIDTH;
      r.cfg[`SRFB_R_PCW] = `SRFB_RST_ZERO;
      r.cfg[`SRFB_R_PCD] = `SRFB_RST_ZERO;
      r.cfg[`SRFB_R_PCTC] = `SRFB_RST_PCTC;
      r.cfg[`SRFB_R_VTHR] = `SRFB_RST_VTHR;
      r.lim = `SRFB_RST_LIM;
      return r;
   endfunction

   localparam srfb_regs_t RST = rst_val();
   // First-order low-pass; a zero time constant gives a plain pass
   function automatic logic signed [23:0] lp_step(input logic signed [23:0] x, input logic signed [23:0] y,
                                                  input longint tc);
      longint df;
      df = longint'(x) - longint'(y);
      return 24'(longint'(y) + df * TS / (tc + TS));
   endfunction

   // State-variable notch, returns output, low-pass and band-pass state
   function automatic logic [71:0] notch_step(input logic signed [23:0] x, input logic signed [23:0] lp,
                                              input logic signed [23:0] bp, input longint f, input longint qd,
                                              input longint g);
      longint hp;
      longint nb;
      longint nl;
      longint y;
      hp = longint'(x) - longint'(lp) - ((qd * longint'(bp)) >>> `SRFB_FRAC);
      nb = longint'(bp) + ((f * hp) >>> `SRFB_FRAC);
      nl = longint'(lp) + ((f * nb) >>> `SRFB_FRAC);
      y = longint'(x) - g * nb / `SRFB_DEPTH_FULL;
      return {24'(y), 24'(nl), 24'(nb)};
   endfunction

   // Notch settings as frequency, width, depth
   function automatic logic [47:0] ncfg(input logic [2:0] k, input logic [`SRFB_NCFG-1:0][15:0] c);
      case (k)
         3'h0: ncfg = {c[`SRFB_R_N1F], c[`SRFB_R_N1W], c[`SRFB_R_N1D]};
         3'h1: ncfg = {c[`SRFB_R_N2F], c[`SRFB_R_N2W], c[`SRFB_R_N2D]};
         3'h2: ncfg = {c[`SRFB_R_N3F], c[`SRFB_R_N3W], c[`SRFB_R_N3D]};
         3'h3: ncfg = {c[`SRFB_R_N4F], c[`SRFB_R_N4W], c[`SRFB_R_N4D]};
         3'h4: ncfg = {c[`SRFB_R_LFF], c[`SRFB_R_LFW], c[`SRFB_R_LFD]};
         default: ncfg = {c[`SRFB_R_PCF], c[`SRFB_R_PCW], c[`SRFB_R_PCD]};
      endcase
   endfunction

   function automatic logic [15:0] sat16(input logic signed [23:0] v);
      if (v > 24'sh007fff) begin
         return 16'h7fff;
      end else if (v < -24'sh008000) begin
         return 16'h8000;
      end
      return v[15:0];
   endfunction

   srfb_regs_t        q;
   srfb_regs_t        d;
   logic [4:0]        idx;
   logic [31:0]       bmask;
   logic [31:0]       rd_mux;
   logic [`SRFB_ST_W-1:0] sset;
   logic [`SRFB_ST_W-1:0] sclr;
   logic [15:0]       ft;
   logic              lp_en;
   logic              nt_en;
   logic              n_on;
   logic [2:0]        nk;
   logic [47:0]       nc;
   logic [15:0]       nfreq;
   logic [71:0]       nr;
   logic signed [23:0] hp;
   logic              hsgn;
   logic [15:0]       vc;
   longint            fco;
   longint            fest;
   logic [32:0]       perr_abs;

   assign idx = avs_address[6:2];
   assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   // Answer one cycle after the request, which keeps the read mux off the bus path
   assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
   assign avs_readdata = q.rdata;
   assign out_valid = q.ovld;
   assign torque_cmd_out = q.tout;
   assign speed_cmd_out = q.sout;
   assign pos_cmd_out = q.pout;
   assign position_error_too_large_fault = q.st[`SRFB_ST_FAULT];
   assign irq = |(q.st & q.mask);

   always_comb begin
      rd_mux = 32'h0;
      if (avs_address[7] == 1'b0 && idx < 5'(`SRFB_NCFG)) begin
         rd_mux = {16'h0, q.cfg[idx]};
      end else if (avs_address[7] == 1'b0) begin
         case (idx)
            5'(`SRFB_R_LIM): rd_mux = q.lim;
            5'(`SRFB_R_STAT): rd_mux = 32'(q.st);
            5'(`SRFB_R_MASK): rd_mux = 32'(q.mask);
            5'(`SRFB_R_AUTO): rd_mux = {15'h0, q.auto_on, q.est};
            default: rd_mux = 32'h0;
         endcase
      end
   end

   always_comb begin
      d = q;
      d.ovld = 1'b0;
      d.ack = 1'b0;
      sset = '0;
      sclr = '0;
      hp = '0;
      hsgn = 1'b0;
      vc = q.vcnt;
      fest = 0;
      nr = '0;
      perr_abs = '0;
      ft = q.cfg[`SRFB_R_TYPE];
      lp_en = (ft == SRFB_FT_LP) || (ft == SRFB_FT_CASCADE) || (ft == SRFB_FT_AUTO && q.auto_on);
      nt_en = (ft == SRFB_FT_NOTCH) || (ft == SRFB_FT_CASCADE) || (ft == SRFB_FT_AUTO && q.auto_on);
      nk = 3'(q.stg - 3'(`SRFB_STG_N1));
      nc = ncfg(nk, q.cfg);
      // Computed notch frequency replaces the first notch
      nfreq = (nk == 3'h0 && ft == SRFB_FT_AUTO && q.auto_on) ? q.est : nc[47:32];
      // Zero frequency switches a notch off
      n_on = (nfreq != 16'h0) && (nk >= 3'(`SRFB_N_SPD) || nt_en);
      fco = longint'(nfreq) * `SRFB_TWO_PI_Q15 / SAMPLE_HZ;
      if (nk >= 3'(`SRFB_N_SPD)) begin
         fco = fco / `SRFB_TENTH;
      end
      // Clamped so the recursion stays stable near half the sample rate
      if (fco > `SRFB_F_MAX) begin
         fco = `SRFB_F_MAX;
      end
      // Register writes at the accepting edge
      if ((avs_read | avs_write) & ~q.ack) begin
         d.ack = 1'b1;
         d.rdata = rd_mux;
      end
      if (avs_write & q.ack & ~avs_address[7]) begin
         if (idx < 5'(`SRFB_NCFG)) begin
            d.cfg[idx] = (q.cfg[idx] & ~bmask[15:0]) | (avs_writedata[15:0] & bmask[15:0]);
         end else if (idx == 5'(`SRFB_R_LIM)) begin
            d.lim = (q.lim & ~bmask) | (avs_writedata & bmask);
         end else if (idx == 5'(`SRFB_R_STAT) && avs_byteenable[0]) begin
            sclr = avs_writedata[`SRFB_ST_W-1:0];
         end else if (idx == 5'(`SRFB_R_MASK) && avs_byteenable[0]) begin
            d.mask = avs_writedata[`SRFB_ST_W-1:0];
         end
      end
      case (q.fsm)
         SRFB_IDLE: begin
            if (sample_valid) begin
               d.tin = torque_cmd_in;
               d.sin = speed_cmd_in;
               d.pin = pos_cmd_in;
               d.perr = pos_error_in;
               d.tq = 24'($signed(torque_cmd_in));
               d.sp = 24'($signed(speed_cmd_in));
               d.pc = 24'($signed(pos_cmd_in));
               d.stg = 3'h0;
               d.fsm = SRFB_RUN;
               // Crossing count over a window estimates the oscillation frequency
               if (ft != SRFB_FT_AUTO) begin
                  d.auto_on = 1'b0;
                  d.vcnt = '0;
                  d.vwin = '0;
               end else if (!q.auto_on) begin
                  hp = 24'($signed(torque_cmd_in)) - q.tlp;
                  hsgn = hp[23];
                  // Small swings below the threshold are ignored
                  if ((hsgn ? -hp : hp) > 24'(q.cfg[`SRFB_R_VTHR])) begin
                     d.vsgn = hsgn;
                     if (hsgn != q.vsgn) begin
                        vc = q.vcnt + 16'h1;
                     end
                  end
                  d.vcnt = vc;
                  d.vwin = q.vwin + 16'h1;
                  if (q.vwin == 16'(VIB_WIN - 1)) begin
                     fest = longint'(vc) * SAMPLE_HZ / (2 * VIB_WIN);
                     d.vcnt = '0;
                     d.vwin = '0;
                     if (fest > `SRFB_VIB_HZ) begin
                        d.auto_on = 1'b1;
                        d.est = 16'(fest);
                        sset[`SRFB_ST_VIB] = 1'b1;
                     end
                  end
               end
            end
         end
         SRFB_RUN: begin
            d.stg = q.stg + 3'h1;
            if (q.stg == 3'h0) begin
               // Torque low-pass, state tracks even while unused
               d.tlp = lp_step(q.tq, q.tlp, longint'(q.cfg[`SRFB_R_LPTC]));
               if (lp_en) begin
                  d.tq = d.tlp;
               end
            end else if (q.stg <= 3'(`SRFB_STG_PC)) begin
               // One notch per cycle, each with its own state
               nr = notch_step((q.stg == 3'(`SRFB_STG_SPD)) ? q.sp : ((q.stg == 3'(`SRFB_STG_PC)) ? q.pc : q.tq),
                               q.nlp[nk], q.nbp[nk], fco, longint'(nc[31:16]) * `SRFB_Q_PER_TENTH,
                               longint'(`SRFB_DEPTH_FULL) - longint'(nc[15:0]));
               // Disabled notch passes and restarts clean
               if (n_on) begin
                  d.nlp[nk] = nr[47:24];
                  d.nbp[nk] = nr[23:0];
                  if (q.stg == 3'(`SRFB_STG_SPD)) begin
                     d.sp = nr[71:48];
                  end else if (q.stg == 3'(`SRFB_STG_PC)) begin
                     d.pc = nr[71:48];
                  end else begin
                     d.tq = nr[71:48];
                  end
               end else begin
                  d.nlp[nk] = '0;
                  d.nbp[nk] = '0;
               end
            end else begin
               // Position command low-pass in 0.1 ms units
               d.plp = lp_step(q.pc, q.plp, longint'(q.cfg[`SRFB_R_PCTC]) * `SRFB_PC_TC_MUL);
               d.tout = sat16(q.tq);
               d.sout = sat16(q.sp);
               d.pout = sat16(d.plp);
               d.ovld = 1'b1;
               d.fsm = SRFB_IDLE;
               perr_abs = q.perr[31] ? 33'h0 - {1'b1, q.perr} : {1'b0, q.perr};
               // Error check, off at zero limit
               if (q.lim != 32'h0 && perr_abs > {1'b0, q.lim}) begin
                  sset[`SRFB_ST_FAULT] = 1'b1;
               end
            end
         end
         default: d.fsm = SRFB_IDLE;
      endcase
      // New events win over a clear in the same cycle
      d.st = (q.st & ~sclr) | sset;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   property p_none_pass;
      @(posedge ref_clk) disable iff (!rst_n)
      (q.ovld && q.cfg[`SRFB_R_TYPE] == SRFB_FT_NONE && $stable(q.cfg)) |-> (torque_cmd_out == q.tin);
   endproperty
   a_none_pass: assert property (p_none_pass) else $error("Torque changed with filtering off");

   property p_spd_pass;
      @(posedge ref_clk) disable iff (!rst_n)
      (q.ovld && q.cfg[`SRFB_R_LFF] == 16'h0) |-> (speed_cmd_out == q.sin);
   endproperty
   a_spd_pass: assert property (p_spd_pass) else $error("Speed changed with its notch off");

   property p_pc_pass;
      @(posedge ref_clk) disable iff (!rst_n)
      (q.ovld && q.cfg[`SRFB_R_PCF] == 16'h0 && q.cfg[`SRFB_R_PCTC] == 16'h0) |-> (pos_cmd_out == q.pin);
   endproperty
   a_pc_pass: assert property (p_pc_pass) else $error("Position command changed with filters off");

   property p_lim_off;
      @(posedge ref_clk) disable iff (!rst_n)
      (q.lim == 32'h0 && !q.st[`SRFB_ST_FAULT]) |=> !q.st[`SRFB_ST_FAULT];
   endproperty
   a_lim_off: assert property (p_lim_off) else $error("Fault rose with zero limit");

   property p_fault;
      @(posedge ref_clk) disable iff (!rst_n)
      (q.fsm == SRFB_RUN && q.stg == 3'(`SRFB_STG_LAST) && q.lim != 32'h0 && !q.perr[31] && q.perr > q.lim)
      |=> (position_error_too_large_fault && out_valid);
   endproperty
   a_fault: assert property (p_fault) else $error("Fault missed on large error");

   property p_auto_off;
      @(posedge ref_clk) disable iff (!rst_n)
      (q.fsm == SRFB_IDLE && sample_valid && q.cfg[`SRFB_R_TYPE] != SRFB_FT_AUTO) |=> !q.auto_on;
   endproperty
   a_auto_off: assert property (p_auto_off) else $error("Auto filtering kept outside auto mode");

   property p_latency;
      @(posedge ref_clk) disable iff (!rst_n)
      (q.fsm == SRFB_IDLE && sample_valid) |-> ##1 !out_valid [*8] ##1 out_valid;
   endproperty
   a_latency: assert property (p_latency) else $error("Sample not finished in nine cycles");

   property p_write;
      @(posedge ref_clk) disable iff (!rst_n)
      (avs_write && !avs_waitrequest && avs_address == 8'(`SRFB_R_LPTC * 4) && avs_byteenable == 4'hf)
      |=> (q.cfg[`SRFB_R_LPTC] == $past(avs_writedata[15:0]));
   endproperty
   a_write: assert property (p_write) else $error("Setting write lost");

endmodule

// *** verif/srfb_loop_model.sv ***
`timescale 1ns/1ps
module srfb_loop_model (
   // Clock
   input  wire logic        ref_clk,
   // Samples towards the filter bank
   output logic             sample_valid,
   output logic [15:0]      torque_cmd_in,
   output logic [15:0]      speed_cmd_in,
   output logic [15:0]      pos_cmd_in,
   output logic [31:0]      pos_error_in,
   // Filtered samples back
   input  wire logic        out_valid
);
   initial begin
      sample_valid = 1'b0;
      torque_cmd_in = 16'h0000;
      speed_cmd_in = 16'h0000;
      pos_cmd_in = 16'h0000;
      pos_error_in = 32'h00000000;
   end
   // Offer one sample and count edges to the answer, lat stays 0 on a hang
   task automatic send(input logic [15:0] t, input logic [15:0] s, input logic [31:0] e, output int lat);
      lat = 0;
      @(posedge ref_clk);
      sample_valid <= 1'b1;
      torque_cmd_in <= t;
      speed_cmd_in <= s;
      pos_cmd_in <= s;
      pos_error_in <= e;
      @(posedge ref_clk);
      // Lines change after capture so a late sampler sees garbage, not the value
      sample_valid <= 1'b0;
      torque_cmd_in <= ~t;
      speed_cmd_in <= ~s;
      pos_cmd_in <= ~s;
      pos_error_in <= ~e;
      for (int n = 1; n <= 20 && lat == 0; n++) begin
         @(posedge ref_clk);
         #1;
         if (out_valid === 1'b1) lat = n;
      end
   endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
`include "srfb_consts.svh"
module tb;
   import srfb_pkg::*;
   logic        ref_clk;
   logic        rst_n;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        sample_valid;
   logic [15:0] torque_cmd_in;
   logic [15:0] speed_cmd_in;
   logic [15:0] pos_cmd_in;
   logic [31:0] pos_error_in;
   logic        out_valid;
   logic [15:0] torque_cmd_out;
   logic [15:0] speed_cmd_out;
   logic [15:0] pos_cmd_out;
   logic        position_error_too_large_fault;
   logic        irq;
   logic [31:0] q;
   int          lat;
   int          n_fail = 0;
   int          samples_checked = 0;

   initial ref_clk = 1'b0;
   always #50 ref_clk = ~ref_clk;

   srfb_top #(.SAMPLE_HZ(10000), .VIB_WIN(10)) u_srfb_top (
      .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid),
      .torque_cmd_in(torque_cmd_in), .speed_cmd_in(speed_cmd_in), .pos_cmd_in(pos_cmd_in),
      .pos_error_in(pos_error_in), .out_valid(out_valid), .torque_cmd_out(torque_cmd_out),
      .speed_cmd_out(speed_cmd_out), .pos_cmd_out(pos_cmd_out),
      .position_error_too_large_fault(position_error_too_large_fault), .irq(irq));

   srfb_loop_model u_srfb_loop_model (
      .ref_clk(ref_clk), .sample_valid(sample_valid), .torque_cmd_in(torque_cmd_in),
      .speed_cmd_in(speed_cmd_in), .pos_cmd_in(pos_cmd_in), .pos_error_in(pos_error_in),
      .out_valid(out_valid));

   task automatic conclude();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   // Avalon master: hold the request until waitrequest is sampled low
   task automatic bus(input logic wr, input int idx, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge ref_clk);
      avs_address <= 8'(idx * 4);
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      // Look just after each edge, so the next edge is the one that sees waitrequest low
      for (n = 0; n < 50; n++) begin
         #1;
         if (avs_waitrequest === 1'b0) break;
         @(posedge ref_clk);
      end
      @(posedge ref_clk);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n == 50) begin
         chk(1'b0, "bus timeout");
         conclude();
      end
   endtask

   // One sample through the loop model; a lost answer counts as a mismatch
   task automatic smp(input logic [15:0] t, input logic [15:0] s, input logic [31:0] e);
      u_srfb_loop_model.send(t, s, e, lat);
      if (lat == 0) chk(1'b0, "sample timeout");
   endtask

   task automatic t_reset();
      int          ix[13] = '{`SRFB_R_TYPE, `SRFB_R_LPTC, `SRFB_R_N1F, `SRFB_R_N1D, `SRFB_R_N1W, `SRFB_R_N4W,
                              `SRFB_R_LFW, `SRFB_R_LFD, `SRFB_R_PCW, `SRFB_R_PCD, `SRFB_R_PCTC, `SRFB_R_LIM,
                              `SRFB_R_STAT};
      logic [31:0] ex[13] = '{32'h0, 32'h50, 32'h0, 32'h64, 32'h1f4, 32'h1f4, 32'h1f4, 32'h64, 32'h0, 32'h0,
                              32'ha, 32'ha, 32'h0};
      for (int i = 0; i < 13; i++) begin
         bus(1'b0, ix[i], 32'h0, q);
         chk(q === ex[i], "reset value");
      end
   endtask

   task automatic t_access();
      bus(1'b1, `SRFB_R_N3F, 32'h7fff, q);
      bus(1'b0, `SRFB_R_N3F, 32'h0, q);
      chk(q === 32'h7fff, "notch frequency top");
      bus(1'b1, `SRFB_R_N3F, 32'h0, q);
      bus(1'b1, 32, 32'h5a5a, q);
      bus(1'b0, 32, 32'h0, q);
      chk(q === 32'h0, "unmapped read");
   endtask

   task automatic t_types();
      bus(1'b1, `SRFB_R_LPTC, 32'h28, q);
      bus(1'b0, `SRFB_R_LPTC, 32'h0, q);
      chk(q === 32'h28, "time constant write");
      bus(1'b1, `SRFB_R_TYPE, 32'h2, q);
      smp(16'h1234, 16'h0567, 32'h0);
      chk(lat == 8, "latency");
      chk(torque_cmd_out === 16'h1234, "type 2 pass");
      chk(speed_cmd_out === 16'h0567, "speed notch off");
      chk(pos_cmd_out !== 16'h0567, "position low-pass");
      bus(1'b1, `SRFB_R_TYPE, 32'h1, q);
      smp(16'h2222, 16'h0567, 32'h0);
      chk(torque_cmd_out === 16'h2222, "notches off pass");
      bus(1'b1, `SRFB_R_TYPE, 32'h0, q);
      smp(16'h6000, 16'h0567, 32'h0);
      chk(torque_cmd_out !== 16'h6000 && lat == 8, "low-pass applied");
      bus(1'b1, `SRFB_R_TYPE, 32'h3, q);
      smp(16'h1000, 16'h0567, 32'h0);
      chk(torque_cmd_out !== 16'h1000, "cascade low-pass");
      bus(1'b1, `SRFB_R_PCTC, 32'h0, q);
      smp(16'h0, 16'h0123, 32'h0);
      chk(pos_cmd_out === 16'h0123, "position filters off");
   endtask

   // Alternating swings give nine sign changes in a ten-sample window
   task automatic t_auto();
      bus(1'b1, `SRFB_R_TYPE, 32'h4, q);
      for (int i = 0; i < 10; i++) smp(i[0] ? 16'hc000 : 16'h4000, 16'h0, 32'h0);
      bus(1'b0, `SRFB_R_AUTO, 32'h0, q);
      chk(q[`SRFB_AUTO_BIT] === 1'b1 && q[15:0] === 16'd4500, "auto engaged");
      bus(1'b0, `SRFB_R_STAT, 32'h0, q);
      chk(q[`SRFB_ST_VIB] === 1'b1, "vibration status");
      bus(1'b1, `SRFB_R_TYPE, 32'h2, q);
      smp(16'h0, 16'h0, 32'h0);
      bus(1'b0, `SRFB_R_AUTO, 32'h0, q);
      chk(q[`SRFB_AUTO_BIT] === 1'b0, "auto left");
   endtask

   task automatic t_fault();
      smp(16'h0, 16'h0, 32'ha);
      chk(position_error_too_large_fault === 1'b0, "error at limit");
      smp(16'h0, 16'h0, 32'hb);
      chk(position_error_too_large_fault === 1'b1, "positive error over limit");
      bus(1'b1, `SRFB_R_STAT, 32'h1, q);
      #1;
      chk(position_error_too_large_fault === 1'b0, "fault cleared");
      smp(16'h0, 16'h0, 32'hfffffff5);
      chk(position_error_too_large_fault === 1'b1, "error over limit");
      chk(irq === 1'b0, "masked irq");
      bus(1'b1, `SRFB_R_MASK, 32'h1, q);
      @(posedge ref_clk);
      chk(irq === 1'b1, "irq unmasked");
      bus(1'b0, `SRFB_R_STAT, 32'h0, q);
      chk(q[`SRFB_ST_FAULT] === 1'b1, "status fault bit");
      bus(1'b1, `SRFB_R_STAT, 32'h1, q);
      @(posedge ref_clk);
      #1;
      chk(position_error_too_large_fault === 1'b0 && irq === 1'b0, "clear");
      bus(1'b1, `SRFB_R_LIM, 32'h0, q);
      smp(16'h0, 16'h0, 32'h7fffffff);
      chk(position_error_too_large_fault === 1'b0, "limit zero off");
   endtask

   initial begin
      rst_n = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_access();
      t_types();
      t_auto();
      t_fault();
      conclude();
   end

   initial begin
      #2000000;
      n_fail++;
      conclude();
   end
endmodule
